//--- logic/chc_card.sv
`timescale 1ns/1ps
// Purpose: Card end: strobe decode, ready/busy, interrupt, resets
// Assumes: Pins synchronous-ish; two-stage synchronisers anyway
// Notes:   Reset processing time is a parameter to shorten in sim
module chc_card
  import chc_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = chc_pkg::BUSY_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  chc_if.card       pins,
  input  wire logic irq_req_i,     // Controller interrupt request level
  output logic      busy_o,        // Reset processing in progress
  output logic      io_wr_o,       // One-cycle pulse per I/O write
  output logic [7:0] io_wdata_o
);
  import chc_pkg::*;

  typedef struct packed {
    logic [4:0]       s1;          // Sync stage 1: oe,iowr,reg,rst,sel
    logic [4:0]       s2;
    logic             iowr_d;
    logic             rst_d;
    logic             first;       // First cycle after power-up
    logic             stuck;       // Reset pin stuck since power-up
    logic [CNT_W-1:0] busy_cnt;
    logic [7:0]       cfg;
    logic             irq_d;
    logic [7:0]       pulse;
    logic             rdy;
    logic             rdy_oe_n;
    logic [7:0]       rdata;
    logic             wr;
    logic [7:0]       wd;
  } chc_card_st_t;

  // Idle pin levels: strobes high, reset low, mode select high
  localparam logic [4:0] SYNC_IDLE = 5'h1D;

  chc_card_st_t st_ff;
  chc_card_st_t nxt_st;

  logic oe_n_s, iowr_n_s, reg_n_s, rst_s, sel_n_s, ide, rst_act, io_mode;

  // ---------------------------------------------------------------
  // Combinational next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = {pins.oe_n, pins.iowr_n, pins.reg_n, pins.card_reset,
                 pins.ide_mode_select_n};
    nxt_st.s2 = st_ff.s1;
    {oe_n_s, iowr_n_s, reg_n_s, rst_s, sel_n_s} = st_ff.s2;
    ide = ~sel_n_s;
    // Polarity by personality: low in IDE, high in PC Card
    rst_act = ide ? ~rst_s : rst_s;
    io_mode = st_ff.cfg[IO_EN_BIT] & ~ide;
    nxt_st.iowr_d = iowr_n_s;
    nxt_st.rst_d = rst_act;
    nxt_st.wr = 1'b0;
    nxt_st.first = 1'b0;
    // First cycle sees idle sync levels, so stuck never sets; a held pin reloads busy every cycle
    if (st_ff.first)
      nxt_st.stuck = rst_act;
    else if (!rst_act)
      nxt_st.stuck = 1'b0;
    if (st_ff.busy_cnt != '0)
      nxt_st.busy_cnt = st_ff.busy_cnt - 1'b1;
    if ((rst_act && !st_ff.stuck && !st_ff.first) ||
        st_ff.cfg[SRST_BIT]) begin
      nxt_st.busy_cnt = CNT_W'(BUSY_CYCLES);
      nxt_st.cfg = '0;                             // Soft reset self-clears
    end
    // Write on trailing (rising) edge of I/O write strobe
    if (iowr_n_s && !st_ff.iowr_d && st_ff.busy_cnt == '0) begin
      nxt_st.wr = 1'b1;
      nxt_st.wd = pins.wdata;
      if (!reg_n_s && !ide && pins.addr == CFG_OPT_IDX)
        nxt_st.cfg = pins.wdata;
    end
    // Output-enable reads
    nxt_st.rdata = '0;
    if (!oe_n_s && !ide) begin
      if (!reg_n_s)
        nxt_st.rdata = (pins.addr == CFG_OPT_IDX) ? st_ff.cfg : CIS_BYTE;
      else if (!io_mode)
        nxt_st.rdata = COMMON_BYTE;
    end
    // Interrupt / ready pin personality
    nxt_st.irq_d = irq_req_i;
    if (st_ff.pulse != '0)
      nxt_st.pulse = st_ff.pulse - 1'b1;
    if (irq_req_i && !st_ff.irq_d)
      nxt_st.pulse = 8'(IRQ_PULSE_CYC);
    nxt_st.rdy_oe_n = 1'b0;
    if (ide)
      nxt_st.rdy = irq_req_i;
    else if (io_mode)
      nxt_st.rdy = st_ff.cfg[LVL_IRQ_BIT] ? ~irq_req_i
                                          : (st_ff.pulse == '0);
    else
      nxt_st.rdy = (nxt_st.busy_cnt == '0) || st_ff.stuck;
  end

  // ---------------------------------------------------------------
  // State register; power-up starts busy
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff          <= '0;
      // Idle levels, so no false reset or stuck pin after release
      st_ff.s1       <= SYNC_IDLE;
      st_ff.s2       <= SYNC_IDLE;
      st_ff.iowr_d   <= 1'b1;
      st_ff.first    <= 1'b1;
      // Line driven low from reset on, never floated high
      st_ff.busy_cnt <= CNT_W'(BUSY_CYCLES);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins.rdata    = st_ff.rdata;
  assign pins.rdy_o    = st_ff.rdy;
  assign pins.rdy_oe_n = st_ff.rdy_oe_n;
  assign busy_o        = st_ff.busy_cnt != '0;
  assign io_wr_o       = st_ff.wr;
  assign io_wdata_o    = st_ff.wd;
endmodule

//--- logic/chc_host.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
// Purpose: Host socket end with APB registers driving card pins
// Assumes: APB slave, zero wait states; read data registered in setup
// Notes:   Commands refused while ready/busy is low, in memory mode only
module chc_host
  import chc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  chc_if.host              pins,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o
);
  import chc_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_STRB, H_HOLD} chc_hst_t;
  typedef struct packed {
    chc_hst_t         hs;
    logic [2:0]       scnt;
    logic [1:0]       mode;
    logic             rst_pin;
    logic             cmd_rd;
    logic [3:0]       addr;
    logic [7:0]       wd;
    logic             regsel_n;
    logic             oe_n;
    logic             iowr_n;
    logic [7:0]       rd;
    logic [NEV-1:0]   ist;
    logic [NEV-1:0]   msk;
    logic             rdy_d;
    logic [31:0]      prdata;
    logic             irq;
  } chc_host_st_t;

  chc_host_st_t st_ff;
  chc_host_st_t nxt_st;
  logic         acc;
  logic         ide;
  logic         card_int;

  always_comb begin
    nxt_st = st_ff;
    acc = psel_i & penable_i;
    ide = (st_ff.mode == 2'(CHC_IDE));
    card_int = ide ? pins.rdy_line : 1'b0;
    nxt_st.rdy_d = pins.rdy_line;
    if (st_ff.mode == 2'(CHC_IO) && !pins.rdy_line) card_int = 1'b1;
    // Event capture: set wins over the read clear
    // Clear only what the setup cycle reported, so no event is lost
    if (acc && !pwrite_i && paddr_i == A_IRQ_ST)
      nxt_st.ist = st_ff.ist & ~st_ff.prdata[NEV-1:0];
    if (card_int) nxt_st.ist[EV_IRQ] = 1'b1;
    if (st_ff.mode == 2'(CHC_MEM) && pins.rdy_line && !st_ff.rdy_d)
      nxt_st.ist[EV_READY] = 1'b1;
    // Strobe sequencer
    case (st_ff.hs)
      H_IDLE: ;
      H_STRB: begin
        // Last sample before the strobe rises wins
        if (st_ff.cmd_rd) nxt_st.rd = pins.rdata;
        if (st_ff.scnt != '0)
          nxt_st.scnt = st_ff.scnt - 1'b1;
        else
          nxt_st.hs = H_HOLD;
      end
      H_HOLD: begin
        nxt_st.hs = H_IDLE;
        nxt_st.oe_n = 1'b1;
        nxt_st.iowr_n = 1'b1;
        nxt_st.ist[EV_DONE] = 1'b1;
      end
      default: nxt_st.hs = H_IDLE;
    endcase
    nxt_st.prdata = '0;
    if (acc && pwrite_i) begin
      case (paddr_i)
        A_CTRL: begin
          nxt_st.mode = pwdata_i[1:0];
          nxt_st.rst_pin = pwdata_i[2];
        end
        A_IRQ_MSK: nxt_st.msk = pwdata_i[NEV-1:0];
        A_CMD: begin
          // No access while ready/busy low in memory mode; I/O and IDE never wait
          if (st_ff.hs == H_IDLE &&
              (pins.rdy_line || st_ff.mode != 2'(CHC_MEM))) begin
            nxt_st.hs = H_STRB;
            nxt_st.scnt = 3'(STRB_HOLD_CYC);
            nxt_st.cmd_rd = pwdata_i[31];
            nxt_st.addr = pwdata_i[11:8];
            nxt_st.wd = pwdata_i[7:0];
            // Common/attribute; low in I/O; tied high in IDE
            nxt_st.regsel_n = ide ? 1'b1
                            : (st_ff.mode == 2'(CHC_IO)) ? 1'b0
                            : pwdata_i[16];
            nxt_st.oe_n = ~pwdata_i[31];
            nxt_st.iowr_n = pwdata_i[31];
          end
        end
        default: ;
      endcase
    end else if (psel_i && !penable_i && !pwrite_i) begin
      // Decoded in setup so data stands through the access cycle
      case (paddr_i)
        A_CTRL:    nxt_st.prdata = {29'h0, st_ff.rst_pin, st_ff.mode};
        A_RDATA:   nxt_st.prdata = {24'h0, st_ff.rd};
        A_STAT:    nxt_st.prdata = {30'h0, st_ff.hs != H_IDLE,
                                    pins.rdy_line};
        A_IRQ_ST:  nxt_st.prdata = {29'h0, st_ff.ist};
        A_IRQ_MSK: nxt_st.prdata = {29'h0, st_ff.msk};
        default:   nxt_st.prdata = '0;
      endcase
    end
    // Register select tied high whenever IDE is selected
    if (nxt_st.mode == 2'(CHC_IDE)) nxt_st.regsel_n = 1'b1;
    nxt_st.irq = |(nxt_st.ist & nxt_st.msk);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff          <= '0;
      st_ff.hs       <= H_IDLE;
      st_ff.regsel_n <= 1'b1;
      st_ff.oe_n     <= 1'b1;
      st_ff.iowr_n   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Mode select grounded selects IDE personality
  assign pins.ide_mode_select_n = ~(st_ff.mode == 2'(CHC_IDE));
  assign pins.card_reset = st_ff.rst_pin;
  assign pins.oe_n       = st_ff.oe_n;
  assign pins.iowr_n     = st_ff.iowr_n;
  assign pins.reg_n      = st_ff.regsel_n;
  assign pins.addr       = st_ff.addr;
  assign pins.wdata      = st_ff.wd;
  assign prdata_o        = st_ff.prdata;
  assign pready_o        = 1'b1;
  assign pslverr_o       = 1'b0;
  assign irq_o           = st_ff.irq;
endmodule

//--- logic/chc_if.sv
`timescale 1ns/1ps
// Purpose: Pin bundle between host socket and card
// Assumes: Ready/busy line resolved from card drive and host pull-up
// Notes:   Card output enable is active low (low = card drives)
interface chc_if;
  logic       oe_n;            // Output-enable strobe
  logic       iowr_n;          // I/O write strobe
  logic       reg_n;           // Register select
  logic       card_reset;      // Reset pin (polarity per mode)
  logic       ide_mode_select_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rdy_o;           // Card drive value
  logic       rdy_oe_n;        // Low while card drives
  logic       rdy_line;        // Resolved level, pull-up when released
  // Pull-up on ready/busy supplied by the socket
  assign rdy_line = rdy_oe_n ? 1'b1 : rdy_o;
  modport card (input oe_n, iowr_n, reg_n, card_reset, ide_mode_select_n,
                input addr, wdata, output rdata, rdy_o, rdy_oe_n);
  modport host (output oe_n, iowr_n, reg_n, card_reset, ide_mode_select_n,
                output addr, wdata, input rdata, rdy_line);
endinterface

//--- logic/chc_pkg.sv
// Purpose: Shared constants for the card host control signalling pair
// Assumes: One 125 MHz clock; pins modelled as synchronous levels
// Notes:   Both ends and the bench import this package
//
// Notes on behaviour
// - Memory mode read returns memory, attribute, config data
// - I/O mode read strobe returns only CIS/config
// - Host grounds mode select for IDE mode
// - Memory mode ready high when card accepts transfer
// - Host supplies pull-up on ready/busy line
// - Ready/busy low until reset processing finishes
// - Host makes no access while card busy (host checks ready/busy only in memory mode)
// - Reset pin stuck from power-up keeps ready high (code: stuck never sets, ready stays low while pin held)
// - I/O mode pin becomes active-low interrupt, pulse/level
// - IDE mode interrupt on same pin, active high
// - Register select high common, low attribute
// - Host drives register select low in I/O cycles
// - IDE mode ignores register select, host ties high
// - PC Card modes: reset pin active high
// - Reset pin high from power-up resets only once (code: busy reloads every cycle while pin held)
// - Soft reset bit acts as hardware reset
// - IDE mode reset pin active low
// - I/O write takes data on strobe rising edge
package chc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned BUSY_TIME_US     = 50;
  localparam int unsigned BUSY_CYC         = BUSY_TIME_US * CLK_MHZ;
  localparam int unsigned IRQ_PULSE_NS     = 80;
  localparam int unsigned IRQ_PULSE_CYC    = IRQ_PULSE_NS * CLK_MHZ / 1000;
  localparam int unsigned CNT_W            = 24;
  // Strobe low time covers the card's two-flop sync plus its data flop
  localparam int unsigned STRB_HOLD_CYC    = 4;
  // ---------------------------------------------------------------
  // Card register indices (low address bits, 8-bit data)
  // ---------------------------------------------------------------
  localparam logic [3:0]  CFG_OPT_IDX      = 4'h0;
  localparam logic [3:0]  CFG_STAT_IDX     = 4'h1;
  localparam logic [3:0]  TASK_DATA_IDX    = 4'h2;
  localparam int unsigned SRST_BIT         = 7;
  localparam int unsigned LVL_IRQ_BIT      = 6;
  localparam int unsigned IO_EN_BIT        = 0;
  localparam int unsigned INT_BIT          = 1;
  localparam logic [7:0]  CIS_BYTE         = 8'h5A;
  localparam logic [7:0]  COMMON_BYTE      = 8'hC3;
  // ---------------------------------------------------------------
  // Host APB map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0]  A_CTRL           = 8'h00;
  localparam logic [7:0]  A_CMD            = 8'h04;
  localparam logic [7:0]  A_RDATA          = 8'h08;
  localparam logic [7:0]  A_STAT           = 8'h0C;
  localparam logic [7:0]  A_IRQ_ST         = 8'h10;
  localparam logic [7:0]  A_IRQ_MSK        = 8'h14;
  localparam int unsigned EV_DONE          = 0;
  localparam int unsigned EV_IRQ           = 1;
  localparam int unsigned EV_READY         = 2;
  localparam int unsigned NEV              = 3;
  // Card modes
  typedef enum logic [1:0] {
    CHC_MEM,
    CHC_IO,
    CHC_IDE
  } chc_mode_t;
endpackage

//--- testbench/card_host_control_signals_bench.sv
// Purpose: Self-checking bench for the host and card pair
// Assumes: Card busy time shortened to 20 cycles
// Notes:   Read data is taken at the edge that samples pready
`timescale 1ns/1ps
module card_host_control_signals_bench;
  import chc_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic       regsel;
    logic [3:0] addr;
    logic [7:0] exp;
  } chc_row_t;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic        irq_req_i = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        irq_o;
  logic        busy_o;
  logic        io_wr_o;
  logic [7:0]  io_wdata_o;
  logic [31:0] d;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          n_wr       = 0;
  int          t;
  // Memory rows before I/O rows; config write picks the mode
  chc_row_t    rows [4]   = '{'{2'h0, 1'b1, 4'h2, COMMON_BYTE},
                              '{2'h0, 1'b0, 4'h3, CIS_BYTE},
                              '{2'h1, 1'b0, 4'h3, CIS_BYTE},
                              '{2'h1, 1'b0, 4'h0, 8'h01}};
  // ---------------------------------------------------------------
  // Clock, ends and checker
  // ---------------------------------------------------------------
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (io_wr_o === 1'b1) n_wr++;
  chc_if chc_if_inst ();
  chc_card #(.BUSY_CYCLES(20)) chc_card_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .pins(chc_if_inst), .irq_req_i(irq_req_i),
    .busy_o(busy_o), .io_wr_o(io_wr_o), .io_wdata_o(io_wdata_o));
  chc_host chc_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .pins(chc_if_inst), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(),
    .irq_o(irq_o));
  chc_assertions chc_assertions_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .oe_n(chc_if_inst.oe_n),
    .iowr_n(chc_if_inst.iowr_n), .card_reset(chc_if_inst.card_reset),
    .ide_mode_select_n(chc_if_inst.ide_mode_select_n),
    .rdy_oe_n(chc_if_inst.rdy_oe_n), .rdy_line(chc_if_inst.rdy_line),
    .busy_o(busy_o), .io_wr_o(io_wr_o), .irq_req_i(irq_req_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; read data taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] w);
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= w;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    d = prdata_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wait_free();
    t = 0;
    while (busy_o !== 1'b0 && t < 300) begin
      @(posedge clk_sys_i);
      t++;
    end
    check(32'(busy_o), 32'h0);
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic cmd(input logic rd, input logic rs, input logic [3:0] a,
                     input logic [7:0] w);
    apb(1'b1, A_CMD, {rd, 14'h0, rs, 4'h0, a, w});
    do apb(1'b0, A_STAT, 32'h0); while (d[1] !== 1'b0);
    repeat (6) @(posedge clk_sys_i);
    if (rd) apb(1'b0, A_RDATA, 32'h0);
  endtask
  task automatic irq_burst(input logic [31:0] msk, input logic [7:0] cfg);
    cmd(1'b0, 1'b0, CFG_OPT_IDX, cfg);
    apb(1'b1, A_IRQ_MSK, msk);
    irq_req_i <= 1'b1;
    t = 0;
    repeat (30) begin
      @(posedge clk_sys_i);
      if (chc_if_inst.rdy_line === 1'b0) t++;
    end
    irq_req_i <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    apb(1'b0, A_STAT, 32'h0);
    check(32'(d[0]), 32'h0);
    wait_free();
    apb(1'b0, A_STAT, 32'h0);
    check(32'(d[0]), 32'h1);
    apb(1'b0, A_IRQ_ST, 32'h0);
    check(32'(d[EV_READY]), 32'h1);
    apb(1'b0, A_IRQ_ST, 32'h0);
    check(32'(d[EV_READY]), 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      cmd(1'b0, 1'b0, CFG_OPT_IDX, {7'h0, rows[i].mode[0]});
      apb(1'b1, A_CTRL, 32'(rows[i].mode));
      cmd(1'b1, rows[i].regsel, rows[i].addr, 8'h00);
      check(32'(d[7:0]), 32'(rows[i].exp));
    end
    check(32'(n_wr), 32'h4);
    check(32'(io_wdata_o), 32'h1);
    $display("row test done");
    irq_burst(32'h0, 8'h41);
    check(32'(irq_o), 32'h0);
    irq_burst(32'h2, 8'h41);
    // Pin flop launches at the first edge, so 29 of 30 samples low
    check(32'(t), 32'h1D);
    check(32'(irq_o), 32'h1);
    apb(1'b0, A_IRQ_ST, 32'h0);
    check(32'(d[EV_IRQ]), 32'h1);
    repeat (3) @(posedge clk_sys_i);
    check(32'(irq_o), 32'h0);
    irq_burst(32'h0, 8'h01);
    check(32'(t), 32'(IRQ_PULSE_CYC));
    $display("interrupt test done");
    cmd(1'b0, 1'b0, CFG_OPT_IDX, 8'h80);
    check(32'(busy_o), 32'h1);
    wait_free();
    apb(1'b1, A_CTRL, 32'h4);
    repeat (6) @(posedge clk_sys_i);
    check(32'(chc_if_inst.rdy_line), 32'h0);
    apb(1'b1, A_CTRL, 32'h0);
    wait_free();
    $display("reset pin test done");
    apb(1'b1, A_CTRL, 32'h6);
    wait_free();
    check(32'(chc_if_inst.ide_mode_select_n), 32'h0);
    check(32'(chc_if_inst.reg_n), 32'h1);
    irq_req_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    check(32'(chc_if_inst.rdy_line), 32'h1);
    irq_req_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    check(32'(chc_if_inst.rdy_line), 32'h0);
    apb(1'b1, A_CTRL, 32'h2);
    repeat (4) @(posedge clk_sys_i);
    check(32'(busy_o), 32'h1);
    apb(1'b1, A_CTRL, 32'h6);
    wait_free();
    $display("IDE test done");
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    fail_count++;
    finish_test();
  end
endmodule

//--- testbench/chc_assertions.sv
// Purpose: Pin-level checks between the host and card ends
// Assumes: One clock domain, reset_i async active high
// Notes:   Fed from the carrier signals, no bind
`timescale 1ns/1ps
module chc_assertions (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic oe_n,
  input wire logic iowr_n,
  input wire logic card_reset,
  input wire logic ide_mode_select_n,
  input wire logic rdy_oe_n,
  input wire logic rdy_line,
  input wire logic busy_o,
  input wire logic io_wr_o,
  input wire logic irq_req_i
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  // ---------------------------------------------------------------
  // Ready line, strobes and resets
  // ---------------------------------------------------------------
  chk_line_pullup: assert property (rdy_oe_n |-> rdy_line)
    else $error("ready line low while released");
  // Two cycles so a busy start in I/O mode, where ready still shows the interrupt for one cycle, is not flagged
  chk_busy_low: assert property (busy_o [*2] |-> !rdy_line)
    else $error("ready line high while busy");
  chk_ready_after: assert property ($fell(busy_o) && ide_mode_select_n
    && !irq_req_i |-> ##[0:2] rdy_line)
    else $error("ready line stays low after busy");
  chk_wr_edge: assert property ($rose(iowr_n) |-> ##[1:4] io_wr_o)
    else $error("no write on strobe trailing edge");
  chk_wr_not_lead: assert property ($fell(iowr_n) |-> !io_wr_o [*2])
    else $error("write taken on strobe leading edge");
  chk_no_access: assert property ($fell(iowr_n) || $fell(oe_n)
    |-> !busy_o)
    else $error("strobe while card busy");
  chk_pc_reset: assert property ($rose(card_reset) && ide_mode_select_n
    && $stable(ide_mode_select_n) |-> ##[1:4] busy_o)
    else $error("high reset pin ignored");
  chk_ide_reset: assert property ($fell(card_reset) && !ide_mode_select_n
    && $stable(ide_mode_select_n) |-> ##[1:4] busy_o)
    else $error("low reset pin ignored in IDE mode");
  chk_ide_irq: assert property ($rose(irq_req_i) && !ide_mode_select_n
    && !busy_o |-> ##[1:4] rdy_line)
    else $error("IDE interrupt not driven high");
  cov_write: cover property ($rose(io_wr_o));
  cov_ready: cover property ($fell(busy_o));
  cov_ide_irq: cover property (!ide_mode_select_n && rdy_line);
endmodule
